// File: rtl/stc_params.svh
// offsets, field positions, reset values and divider counts of the timer
`ifndef STC_PARAMS_SVH
`define STC_PARAMS_SVH
`define STC_A_CTRL_FIRST 8'h00
`define STC_A_CTRL_SECOND 8'h04
`define STC_A_CTRL_THIRD 8'h08
`define STC_A_COUNT_LO 8'h0C
`define STC_A_COUNT_HI 8'h10
`define STC_A_CMPA_LO 8'h14
`define STC_A_CMPA_HI 8'h18
`define STC_A_CMPB_LO 8'h1C
`define STC_A_CMPB_HI 8'h20
`define STC_A_CAP_LO 8'h24
`define STC_A_CAP_HI 8'h28
`define STC_A_IRQ_FLAG 8'h2C
`define STC_A_IRQ_MASK 8'h30
`define STC_A_POWER 8'h34
`define STC_COM_A_POS 6
`define STC_COM_B_POS 4
`define STC_WAVE_LO_POS 0
`define STC_NOISE_EN_POS 7
`define STC_EDGE_POS 6
`define STC_CAP_SRC_POS 5
`define STC_WAVE_HI_POS 3
`define STC_CLK_SEL_POS 0
`define STC_FORCE_A_POS 7
`define STC_FORCE_B_POS 6
`define STC_FLAG_OVF 0
`define STC_FLAG_MA 1
`define STC_FLAG_MB 2
`define STC_FLAG_CAP 5
`define STC_CTRL_RESET 8'h00
`define STC_POWER_RESET 1'b0
`define STC_TOP_8BIT 16'h00FF
`define STC_TOP_9BIT 16'h01FF
`define STC_TOP_10BIT 16'h03FF
`define STC_BOTTOM 16'h0000
`define STC_MAX 16'hFFFF
`define STC_FILTER_LEN 4
`define STC_DIV8_MASK 10'h007
`define STC_DIV64_MASK 10'h03F
`define STC_DIV256_MASK 10'h0FF
`define STC_DIV1024_MASK 10'h3FF
`endif

// File: rtl/stc_pkg.sv
// types shared by the timer modules
package stc_pkg;
  typedef logic [15:0] stc_word_t;
  typedef enum logic [1:0] {STC_NONPWM, STC_FAST, STC_PHASE} stc_wave_t;
  typedef enum logic [2:0] {
    STC_CS_OFF, STC_CS_DIV1, STC_CS_DIV8, STC_CS_DIV64,
    STC_CS_DIV256, STC_CS_DIV1024, STC_CS_EXT_FALL, STC_CS_EXT_RISE
  } stc_clksel_t;
endpackage : stc_pkg

// File: rtl/stc_prescaler.sv
// clock select: prescaler enables and synchronised external count pin
`timescale 1ns/10ps
`default_nettype none
`include "stc_params.svh"
module stc_prescaler
  import stc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [2:0] sel,
  input wire logic ext_pin,
  output logic tick
);
  logic [9:0] div;
  logic ext_s1, ext_s2, ext_s3;
  stc_clksel_t cs;
  assign cs = stc_clksel_t'(sel);
  wire rise = ext_s2 & ~ext_s3;
  wire fall = ~ext_s2 & ext_s3;
  wire [9:0] m8 = `STC_DIV8_MASK;
  wire [9:0] m64 = `STC_DIV64_MASK;
  wire [9:0] m256 = `STC_DIV256_MASK;
  wire [9:0] m1024 = `STC_DIV1024_MASK;
  logic next_tick;
  always_comb begin
    unique case (cs)
      STC_CS_OFF: next_tick = 1'b0;
      STC_CS_DIV1: next_tick = 1'b1;
      STC_CS_DIV8: next_tick = (div & m8) == m8;
      STC_CS_DIV64: next_tick = (div & m64) == m64;
      STC_CS_DIV256: next_tick = (div & m256) == m256;
      STC_CS_DIV1024: next_tick = (div & m1024) == m1024;
      STC_CS_EXT_FALL: next_tick = fall;
      STC_CS_EXT_RISE: next_tick = rise;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div <= 10'h000;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
      tick <= 1'b0;
    end else begin
      div <= enable ? div + 10'h001 : 10'h000;
      ext_s1 <= ext_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      tick <= enable & next_tick;
    end
  end
endmodule : stc_prescaler
`default_nettype wire

// File: rtl/stc_capture_filter.sv
// capture source sync, select and optional noise canceller
`timescale 1ns/10ps
`default_nettype none
`include "stc_params.svh"
module stc_capture_filter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] raw,
  input wire logic src_sel,
  input wire logic filter_en,
  output logic level
);
  logic [1:0] s1, s2;
  logic [`STC_FILTER_LEN-1:0] hist;
  wire src = src_sel ? s2[1] : s2[0];
  wire all_hi = &hist;
  wire all_lo = ~|hist;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 2'h0;
      s2 <= 2'h0;
      hist <= '0;
      level <= 1'b0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      hist <= {hist[`STC_FILTER_LEN-2:0], src};
      if (!filter_en)
        level <= src;
      else if (all_hi | all_lo)
        level <= hist[0];
    end
  end
endmodule : stc_capture_filter
`default_nettype wire

// File: rtl/stc_timer.sv
// sixteen-bit timer core with compare, capture and apb registers
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "stc_params.svh"
module stc_timer
  import stc_pkg::*;
(
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CAPTURE_PIN,
  input wire logic ANALOG_CMP,
  input wire logic EXT_COUNT_PIN,
  input wire logic [3:0] VECTOR_ACK,
  output logic COMPARE_A_PIN,
  output logic COMPARE_A_EN,
  output logic COMPARE_B_PIN,
  output logic COMPARE_B_EN,
  output logic [3:0] IRQ_REQ
);
  function automatic stc_wave_t wave_kind(input logic [3:0] m);
    unique case (m)
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: wave_kind = STC_PHASE;
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: wave_kind = STC_FAST;
      default: wave_kind = STC_NONPWM;
    endcase
  endfunction : wave_kind

  function automatic stc_word_t top_of(input logic [3:0] m,
      input stc_word_t ocra, input stc_word_t icr);
    unique case (m)
      4'h1, 4'h5: top_of = `STC_TOP_8BIT;
      4'h2, 4'h6: top_of = `STC_TOP_9BIT;
      4'h3, 4'h7: top_of = `STC_TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF: top_of = ocra;
      4'h8, 4'hA, 4'hC, 4'hE: top_of = icr;
      default: top_of = `STC_MAX;
    endcase
  endfunction : top_of

  function automatic logic pin_next(input stc_wave_t k,
      input logic [1:0] com, input logic pin, input logic hit,
      input logic wrap, input logic up, input logic frc,
      input logic tog_ok, input logic pwm_ok);
    pin_next = pin;
    if (k == STC_NONPWM) begin
      if (hit | frc) begin
        unique case (com)
          2'b00: pin_next = pin;
          2'b01: pin_next = ~pin;
          2'b10: pin_next = 1'b0;
          2'b11: pin_next = 1'b1;
        endcase
      end
    end else if (com == 2'b01) begin
      if (hit & tog_ok)
        pin_next = ~pin;
    end else if (com[1] & pwm_ok) begin
      if (hit)
        pin_next = (k == STC_FAST || up) ? com[0] : ~com[0];
      else if (wrap && k == STC_FAST)
        pin_next = ~com[0];
    end
  endfunction : pin_next

  logic [7:0] ctrl_first, ctrl_second, temp_high;
  logic [3:0] irq_flag_reg, irq_mask_reg;
  logic power_cut_bit, up_dir, match_block, cap_level_d;
  stc_word_t count_value, capture_value;
  stc_word_t cmpa_buf, cmpb_buf, compare_a_value, compare_b_value;
  logic [31:0] next_rdata;
  logic timer_tick, cap_level;

  // apb decode; writes land in the access cycle, a count or capture
  // low-byte read fills the holding byte at setup, from the same sample
  wire setup = PSEL & ~PENABLE;
  wire access = PSEL & PENABLE & PREADY;
  wire wr = access & PWRITE;
  wire rd = setup & ~PWRITE;
  wire [7:0] wdata = PWDATA[7:0];
  wire wr_first = wr && PADDR == `STC_A_CTRL_FIRST;
  wire wr_second = wr && PADDR == `STC_A_CTRL_SECOND;
  wire wr_third = wr && PADDR == `STC_A_CTRL_THIRD;
  wire wr_cnt_lo = wr && PADDR == `STC_A_COUNT_LO;
  wire wr_a_lo = wr && PADDR == `STC_A_CMPA_LO;
  wire wr_b_lo = wr && PADDR == `STC_A_CMPB_LO;
  wire wr_cap_lo = wr && PADDR == `STC_A_CAP_LO;
  wire wr_flag = wr && PADDR == `STC_A_IRQ_FLAG;
  wire wr_mask = wr && PADDR == `STC_A_IRQ_MASK;
  wire wr_power = wr && PADDR == `STC_A_POWER;
  wire wr_hi = wr && (PADDR == `STC_A_COUNT_HI ||
      PADDR == `STC_A_CMPA_HI || PADDR == `STC_A_CMPB_HI ||
      PADDR == `STC_A_CAP_HI);
  wire rd_cnt_lo = rd && PADDR == `STC_A_COUNT_LO;
  wire rd_cap_lo = rd && PADDR == `STC_A_CAP_LO;
  wire [15:0] wr_word = {temp_high, wdata};

  // mode, top and position of the counter
  wire [3:0] mode = {ctrl_second[`STC_WAVE_HI_POS +: 2],
      ctrl_first[`STC_WAVE_LO_POS +: 2]};
  stc_wave_t kind;
  assign kind = wave_kind(mode);
  wire stc_word_t top = top_of(mode, compare_a_value, capture_value);
  wire ocra_top = mode == 4'h4 || mode == 4'h9 || mode == 4'hB ||
      mode == 4'hF;
  wire icr_top = mode == 4'h8 || mode == 4'hA || mode == 4'hC ||
      mode == 4'hE;
  wire freq_correct = mode == 4'h8 || mode == 4'h9;
  wire at_top = count_value == top;
  wire at_bot = count_value == `STC_BOTTOM;
  wire at_max = count_value == `STC_MAX;
  wire phase_up = up_dir ? ~at_top : at_bot;
  wire stc_word_t count_step = (kind == STC_PHASE) ?
      (phase_up ? count_value + 16'h0001 : count_value - 16'h0001) :
      (at_top ? `STC_BOTTOM : count_value + 16'h0001);

  // compare on every tick except the first after a count write, against the active (buffered) values
  wire hit_a = timer_tick & ~match_block &
      count_value == compare_a_value;
  wire hit_b = timer_tick & ~match_block &
      count_value == compare_b_value;
  wire wrap = timer_tick & at_top;
  wire buf_load = (kind == STC_NONPWM) |
      (freq_correct ? timer_tick & at_bot : wrap);
  wire ovf_evt = (kind == STC_NONPWM) ? timer_tick & at_max :
      (kind == STC_FAST) ? wrap :
      timer_tick & at_bot & ~up_dir;
  wire force_a = wr_third & wdata[`STC_FORCE_A_POS];
  wire force_b = wr_third & wdata[`STC_FORCE_B_POS];

  // capture edge; no capture while capture register is top
  wire cap_edge = (cap_level != cap_level_d) &
      (cap_level == ctrl_second[`STC_EDGE_POS]);
  wire cap_take = cap_edge & ~icr_top;
  wire cap_evt = cap_take | (icr_top & wrap);
  wire [3:0] set_evt = {cap_evt, hit_b, hit_a, ovf_evt};
  wire [3:0] clr_evt = VECTOR_ACK |
      (wr_flag ? {wdata[`STC_FLAG_CAP], wdata[`STC_FLAG_MB],
      wdata[`STC_FLAG_MA], wdata[`STC_FLAG_OVF]} : 4'h0);
  wire [3:0] next_flag = set_evt | (irq_flag_reg & ~clr_evt);

  wire next_pin_a = pin_next(kind,
      ctrl_first[`STC_COM_A_POS +: 2], COMPARE_A_PIN, hit_a, wrap,
      up_dir, force_a, ocra_top, ~ocra_top);
  wire next_pin_b = pin_next(kind,
      ctrl_first[`STC_COM_B_POS +: 2], COMPARE_B_PIN, hit_b, wrap,
      up_dir, force_b, 1'b0, 1'b1);

  stc_prescaler u_prescaler (
    .clk(CLOCK),
    .rst_n(NRST),
    .enable(~power_cut_bit),
    .sel(ctrl_second[`STC_CLK_SEL_POS +: 3]),
    .ext_pin(EXT_COUNT_PIN),
    .tick(timer_tick)
  );

  stc_capture_filter u_capture_filter (
    .clk(CLOCK),
    .rst_n(NRST),
    .raw({ANALOG_CMP, CAPTURE_PIN}),
    .src_sel(ctrl_second[`STC_CAP_SRC_POS]),
    .filter_en(ctrl_second[`STC_NOISE_EN_POS]),
    .level(cap_level)
  );

  // read mux; flag and mask sit at their own bit positions
  wire [7:0] flag_byte = {2'b00, irq_flag_reg[3], 2'b00,
      irq_flag_reg[2:0]};
  wire [7:0] mask_byte = {2'b00, irq_mask_reg[3], 2'b00,
      irq_mask_reg[2:0]};
  logic map_hit;
  always_comb begin
    map_hit = 1'b1;
    next_rdata = 32'h0000_0000;
    unique case (PADDR)
      `STC_A_CTRL_FIRST: next_rdata[7:0] = ctrl_first;
      `STC_A_CTRL_SECOND: next_rdata[7:0] = ctrl_second;
      `STC_A_CTRL_THIRD: next_rdata[7:0] = 8'h00;
      `STC_A_COUNT_LO: next_rdata[7:0] = count_value[7:0];
      `STC_A_COUNT_HI: next_rdata[7:0] = temp_high;
      `STC_A_CMPA_LO: next_rdata[7:0] = cmpa_buf[7:0];
      `STC_A_CMPA_HI: next_rdata[7:0] = cmpa_buf[15:8];
      `STC_A_CMPB_LO: next_rdata[7:0] = cmpb_buf[7:0];
      `STC_A_CMPB_HI: next_rdata[7:0] = cmpb_buf[15:8];
      `STC_A_CAP_LO: next_rdata[7:0] = capture_value[7:0];
      `STC_A_CAP_HI: next_rdata[7:0] = temp_high;
      `STC_A_IRQ_FLAG: next_rdata[7:0] = flag_byte;
      `STC_A_IRQ_MASK: next_rdata[7:0] = mask_byte;
      `STC_A_POWER: next_rdata[0] = power_cut_bit;
      default: map_hit = 1'b0;
    endcase
  end

  // apb answer: pready high in the cycle after setup
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup & ~map_hit;
      if (setup)
        PRDATA <= next_rdata;
    end
  end

  // control, mask and power registers
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ctrl_first <= `STC_CTRL_RESET;
      ctrl_second <= `STC_CTRL_RESET;
      irq_mask_reg <= 4'h0;
      power_cut_bit <= `STC_POWER_RESET;
    end else begin
      if (wr_first)
        ctrl_first <= wdata;
      if (wr_second)
        ctrl_second <= wdata;
      if (wr_mask)
        irq_mask_reg <= {wdata[`STC_FLAG_CAP], wdata[`STC_FLAG_MB],
            wdata[`STC_FLAG_MA], wdata[`STC_FLAG_OVF]};
      if (wr_power)
        power_cut_bit <= wdata[0];
    end
  end

  // shared high byte holding register
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST)
      temp_high <= 8'h00;
    else if (wr_hi)
      temp_high <= wdata;
    else if (rd_cnt_lo)
      temp_high <= count_value[15:8];
    else if (rd_cap_lo)
      temp_high <= capture_value[15:8];
  end

  // counter and direction; a cpu write wins over any count
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      count_value <= `STC_BOTTOM;
      up_dir <= 1'b1;
      match_block <= 1'b0;
    end else begin
      if (wr_cnt_lo)
        count_value <= wr_word;
      else if (timer_tick)
        count_value <= count_step;
      if (kind != STC_PHASE)
        up_dir <= 1'b1;
      else if (timer_tick)
        up_dir <= phase_up;
      if (wr_cnt_lo)
        match_block <= 1'b1;
      else if (timer_tick)
        match_block <= 1'b0;
    end
  end

  // compare buffers and active values, capture register
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      cmpa_buf <= 16'h0000;
      cmpb_buf <= 16'h0000;
      compare_a_value <= 16'h0000;
      compare_b_value <= 16'h0000;
      capture_value <= 16'h0000;
      cap_level_d <= 1'b0;
    end else begin
      if (wr_a_lo)
        cmpa_buf <= wr_word;
      if (wr_b_lo)
        cmpb_buf <= wr_word;
      if (buf_load) begin
        compare_a_value <= cmpa_buf;
        compare_b_value <= cmpb_buf;
      end
      cap_level_d <= cap_level;
      if (cap_take)
        capture_value <= count_value;
      else if (wr_cap_lo)
        capture_value <= wr_word;
    end
  end

  // flags (set wins over clear), requests and output pins
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      irq_flag_reg <= 4'h0;
      IRQ_REQ <= 4'h0;
      COMPARE_A_PIN <= 1'b0;
      COMPARE_B_PIN <= 1'b0;
      COMPARE_A_EN <= 1'b0;
      COMPARE_B_EN <= 1'b0;
    end else begin
      irq_flag_reg <= next_flag;
      IRQ_REQ <= next_flag & irq_mask_reg;
      COMPARE_A_PIN <= next_pin_a;
      COMPARE_B_PIN <= next_pin_b;
      COMPARE_A_EN <= |ctrl_first[`STC_COM_A_POS +: 2];
      COMPARE_B_EN <= |ctrl_first[`STC_COM_B_POS +: 2];
    end
  end
endmodule : stc_timer
`default_nettype wire

// File: sim/stc_timer_checker.sv
// concurrent checks on the timer's bus, enable and request ports
`timescale 1ns/10ps
`default_nettype none
module stc_timer_checker (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [3:0] VECTOR_ACK,
  input wire logic COMPARE_A_EN,
  input wire logic COMPARE_B_EN,
  input wire logic [3:0] IRQ_REQ
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  wire setup = PSEL && !PENABLE;
  wire wr_done = PSEL && PENABLE && PREADY && PWRITE;
  wire ack_ovf = VECTOR_ACK[0];
  logic [3:0] com_q;
  // output mode fields of the last first-control write
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) com_q <= 4'h0;
    else if (wr_done && PADDR == 8'h00) com_q <= PWDATA[7:4];
  end
  property p_ready_next; setup |=> PREADY; endproperty
  a_ready_next: assert property (p_ready_next)
    else $error("no ready after setup");
  property p_ready_only; PREADY |-> PSEL && PENABLE && $past(setup);
  endproperty
  a_ready_only: assert property (p_ready_only)
    else $error("ready outside access");
  property p_err_ready; PSLVERR |-> PREADY; endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("error without ready");
  property p_unmapped;
    setup && PADDR > 8'h34 |=> PSLVERR && PRDATA == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  property p_narrow; PREADY && !PWRITE |-> PRDATA[31:8] == 24'h0;
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("read data wider than a byte");
  property p_mask_zero;
    wr_done && PADDR == 8'h30 && PWDATA[7:0] == 8'h00
      |-> ##2 IRQ_REQ == 4'h0;
  endproperty
  a_mask_zero: assert property (p_mask_zero)
    else $error("request passes a cleared mask");
  property p_en_a;
    wr_done && PADDR == 8'h00 |-> ##2 COMPARE_A_EN == (com_q[3:2] != 2'h0);
  endproperty
  a_en_a: assert property (p_en_a)
    else $error("pin a enable wrong");
  property p_en_b;
    wr_done && PADDR == 8'h00 |-> ##2 COMPARE_B_EN == (com_q[1:0] != 2'h0);
  endproperty
  a_en_b: assert property (p_en_b)
    else $error("pin b enable wrong");
  property p_quiet; $rose(NRST) |-> IRQ_REQ == 4'h0 && !COMPARE_A_EN;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("outputs active after reset");
  property p_irq_drop;
    $fell(IRQ_REQ[0]) |-> $past(ack_ovf) || $past(wr_done);
  endproperty
  a_irq_drop: assert property (p_irq_drop)
    else $error("overflow request dropped without cause");
endmodule : stc_timer_checker
bind stc_timer stc_timer_checker chk_u (.CLOCK(CLOCK), .NRST(NRST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .VECTOR_ACK(VECTOR_ACK), .COMPARE_A_EN(COMPARE_A_EN),
  .COMPARE_B_EN(COMPARE_B_EN), .IRQ_REQ(IRQ_REQ));
`default_nettype wire

// File: sim/stc_cpu_model.sv
// processor model that runs the vector of the lowest pending request
`timescale 1ns/10ps
`default_nettype none
module stc_cpu_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] irq,
  input wire logic [3:0] delay,
  output logic [3:0] ack
);
  logic [3:0] wait_cnt;
  wire [3:0] first_req = irq & (~irq + 4'h1);
  // one-cycle acknowledge after a chosen latency
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 4'h0;
      wait_cnt <= 4'h0;
    end else if (ack != 4'h0 || irq == 4'h0) begin
      ack <= 4'h0;
      wait_cnt <= 4'h0;
    end else if (wait_cnt >= delay) begin
      ack <= first_req;
      wait_cnt <= 4'h0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule : stc_cpu_model
`default_nettype wire

// File: sim/sixteen_bit_timer_core_bench.sv
// self-checking bench for the sixteen-bit timer core
`timescale 1ns/10ps
`default_nettype none
`include "stc_params.svh"
module sixteen_bit_timer_core_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic cap_pin = 1'b0, cmp_in = 1'b0, ext_pin = 1'b0, irq_seen = 1'b0;
  logic [3:0] delay = 4'h5;
  logic [15:0] v;
  logic [32:0] q[$];
  int err_total = 0, cmp_count = 0, cyc = 0;
  wire [31:0] prdata;
  wire pready, pslverr, pin_a, en_a, pin_b, en_b;
  wire [3:0] ack, irq;
  always #4 clk = ~clk;
  stc_timer dut_u (.CLOCK(clk), .NRST(nrst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CAPTURE_PIN(cap_pin), .ANALOG_CMP(cmp_in), .EXT_COUNT_PIN(ext_pin),
    .VECTOR_ACK(ack), .COMPARE_A_PIN(pin_a), .COMPARE_A_EN(en_a),
    .COMPARE_B_PIN(pin_b), .COMPARE_B_EN(en_b), .IRQ_REQ(irq));
  stc_cpu_model cpu_u (.clk(clk), .rst_n(nrst), .irq(irq), .delay(delay),
    .ack(ack));
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("mismatches %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    q.push_back(e);
    xfer(1'b0, a, 8'h00);
  endtask : rd
  task automatic wr16(input logic [7:0] lo, input logic [15:0] val);
    wr(lo + 8'h04, val[15:8]);
    wr(lo, val[7:0]);
  endtask : wr16
  task automatic rd16(input logic [7:0] lo, input logic [15:0] val);
    rd(lo, {25'h0, val[7:0]});
    rd(lo + 8'h04, {25'h0, val[15:8]});
  endtask : rd16
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_n
  task automatic pulse_ext;
    ext_pin <= 1'b1;
    wait_n(4);
    ext_pin <= 1'b0;
    wait_n(4);
  endtask : pulse_ext
  // read results, sticky request watch and hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq[0] === 1'b1) irq_seen <= 1'b1;
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk({pslverr, prdata}, q.pop_front());
    if (cyc > 20000) begin
      err_total++;
      print_verdict;
    end
  end
  initial begin
    void'($urandom(71));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    for (int a = 0; a <= 52; a += 4) rd(8'(a), 33'h0);
    rd(8'h38, {1'b1, 32'h0});
    wr(`STC_A_POWER, 8'h00);
    $display("test reset done");
    wr(`STC_A_CTRL_FIRST, 8'h40);
    wr(`STC_A_CTRL_SECOND, 8'h18);
    wr(`STC_A_CTRL_THIRD, 8'h80);
    rd(`STC_A_CTRL_FIRST, 33'h40);
    rd(`STC_A_CTRL_SECOND, 33'h18);
    rd(`STC_A_CTRL_THIRD, 33'h0);
    chk({32'h0, pin_a}, 33'h1);
    wr(`STC_A_CTRL_SECOND, 8'h00);
    $display("test control done");
    v = 16'($urandom) | 16'h8000;
    wr16(`STC_A_COUNT_LO, v);
    wait_n(5);
    rd16(`STC_A_COUNT_LO, v);
    wr16(`STC_A_CMPA_LO, 16'h0010);
    wr16(`STC_A_CMPB_LO, 16'h0020);
    rd(`STC_A_COUNT_LO, {25'h0, v[7:0]});
    rd(`STC_A_CMPA_HI, 33'h0);
    rd16(`STC_A_CMPB_LO, 16'h0020);
    $display("test access done");
    wr16(`STC_A_COUNT_LO, 16'hFFF0);
    wr(`STC_A_IRQ_FLAG, 8'hFF);
    wr(`STC_A_IRQ_MASK, 8'h01);
    wr(`STC_A_CTRL_SECOND, 8'h01);
    wait_n(20);
    wr(`STC_A_CTRL_SECOND, 8'h00);
    wait_n(10);
    chk({32'h0, irq_seen}, 33'h1);
    rd(`STC_A_IRQ_FLAG, 33'h0);
    wr(`STC_A_IRQ_MASK, 8'h00);
    $display("test overflow done");
    wr(`STC_A_CTRL_FIRST, 8'h70);
    wr16(`STC_A_COUNT_LO, 16'h0000);
    wr(`STC_A_CTRL_SECOND, 8'h01);
    wait_n(40);
    wr(`STC_A_CTRL_SECOND, 8'h00);
    rd(`STC_A_IRQ_FLAG, 33'h06);
    chk({32'h0, pin_a}, 33'h0);
    chk({32'h0, pin_b}, 33'h1);
    wr(`STC_A_IRQ_FLAG, 8'h02);
    rd(`STC_A_IRQ_FLAG, 33'h04);
    $display("test compare done");
    wr16(`STC_A_COUNT_LO, 16'h0000);
    wr(`STC_A_CTRL_SECOND, 8'h07);
    repeat (5) pulse_ext;
    wr(`STC_A_CTRL_SECOND, 8'h06);
    repeat (3) pulse_ext;
    wait_n(6);
    wr(`STC_A_CTRL_SECOND, 8'h00);
    rd16(`STC_A_COUNT_LO, 16'h0008);
    $display("test external done");
    wr16(`STC_A_COUNT_LO, 16'h0000);
    wr(`STC_A_IRQ_FLAG, 8'hFF);
    wr(`STC_A_CTRL_SECOND, 8'h0F);
    repeat (20) pulse_ext;
    wr(`STC_A_CTRL_SECOND, 8'h00);
    rd16(`STC_A_COUNT_LO, 16'h0003);
    rd(`STC_A_IRQ_FLAG, 33'h02);
    $display("test clear on match done");
    v = 16'($urandom);
    wr(`STC_A_IRQ_FLAG, 8'hFF);
    wr16(`STC_A_COUNT_LO, v);
    wr(`STC_A_CTRL_SECOND, 8'h40);
    cap_pin <= 1'b1;
    wait_n(8);
    rd16(`STC_A_CAP_LO, v);
    rd(`STC_A_IRQ_FLAG, 33'h20);
    cap_pin <= 1'b0;
    wr16(`STC_A_COUNT_LO, ~v);
    wr(`STC_A_CTRL_SECOND, 8'hE0);
    cmp_in <= 1'b1;
    wait_n(2);
    cmp_in <= 1'b0;
    wait_n(8);
    rd16(`STC_A_CAP_LO, v);
    cmp_in <= 1'b1;
    wait_n(12);
    rd16(`STC_A_CAP_LO, ~v);
    $display("test capture done");
    wr(`STC_A_CTRL_SECOND, 8'h00);
    wr16(`STC_A_COUNT_LO, 16'h0100);
    wr(`STC_A_POWER, 8'h01);
    wr(`STC_A_CTRL_SECOND, 8'h01);
    wait_n(10);
    rd16(`STC_A_COUNT_LO, 16'h0100);
    rd(`STC_A_POWER, 33'h1);
    wr16(`STC_A_COUNT_LO, 16'h0000);
    wr(`STC_A_CTRL_SECOND, 8'h02);
    wr(`STC_A_POWER, 8'h00);
    wait_n(60);
    rd(`STC_A_COUNT_LO, 33'h07);
    wr(`STC_A_CTRL_SECOND, 8'h00);
    $display("test power done");
    wait_n(4);
    print_verdict;
  end
endmodule : sixteen_bit_timer_core_bench
`default_nettype wire
